/* include/crcgen_cfg.svh */
`ifndef CRCGEN_CFG_SVH
`define CRCGEN_CFG_SVH

`define CRCGEN_WIDTH 16
`define CRCGEN_BYTE 8
`define CRCGEN_POLY 16'h1021
`define CRCGEN_RESET_VALUE 16'h0000
`define CRCGEN_ADDR_HIGH 1'h0
`define CRCGEN_ADDR_LOW 1'h1
`define CRCGEN_CLOCK_MHZ 250

`endif

/* include/crcgen_pkg.sv */
package crcgen_pkg;

  // power mode of the surrounding processor
  typedef enum logic [2:0] {
    PM_RUN = 3'h0,
    PM_WAIT = 3'h1,
    PM_STOP3 = 3'h2,
    PM_STOP2 = 3'h3,
    PM_STOP1 = 3'h4
  } crcgen_pmode_t;

  typedef struct packed {
    logic write;
    logic read;
    logic addr;
    logic [7:0] wdata;
  } crcgen_bus_t;

  typedef enum logic [1:0] {
    SEED_IDLE = 2'h1,
    SEED_WAIT_LOW = 2'h2
  } crcgen_seed_t;

endpackage

/* design/crcgen_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "crcgen_cfg.svh"

// Function
// - checksum held in one 16-bit shift register, remainder and result
// - feedback uses polynomial x16 + x12 + x5 + 1
// - optional transpose bit-reverses data bytes and the result
// - wait mode behaves exactly like run mode
// - stop 1 and 2 halt block; recovery returns it to reset
// - stop 3 freezes state and resumes unchanged in run
// - no external pins; only bus accesses reach the block
// - high write seeds bits 15-8; next low write seeds bits 7-0
// - after seeding each low write is a data byte, msb first
// - eight bits shifted by next bus cycle after data write
// - reads return bits 15-8 or 7-0 of the shift register, or of its 16-bit reversal under transpose
module crcgen_core #(
  parameter logic [15:0] POLY = `CRCGEN_POLY
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // processor power mode
  input wire crcgen_pkg::crcgen_pmode_t powerMode,
  // transpose option
  input wire logic transposeEn,
  // on-chip bus access
  input wire crcgen_pkg::crcgen_bus_t busReq,
  // read data and current result
  output logic [7:0] readData_reg,
  output logic [15:0] result_reg
);

  // access qualification
  logic frozen;
  logic lostPower;
  logic accessOk;
  logic writeHigh;
  logic writeLow;
  logic readHigh;
  logic readLow;

  // seed sequencing
  crcgen_pkg::crcgen_seed_t seed_reg;
  crcgen_pkg::crcgen_seed_t seed_next;
  logic seedLowTaken;
  logic dataTaken;

  // generator
  logic [15:0] shift_reg;
  logic [15:0] shift_next;
  logic [7:0] dataRev;
  logic [7:0] dataByte;
  logic [7:0] feedBit;
  logic [8:0][15:0] stage;
  logic [15:0] foldValue;

  // result view
  logic [15:0] viewRev;
  logic [15:0] viewValue;

  // output registers
  logic [7:0] readData_next;
  logic [15:0] result_next;

  // ------------------------------------------------------------------
  // power modes and bus decode
  // ------------------------------------------------------------------

  // stop 3 holds state; nothing is taken from the bus meanwhile
  assign frozen = (powerMode == crcgen_pkg::PM_STOP3);

  // deep stop: treat as held reset so recovery starts clean
  assign lostPower = (powerMode == crcgen_pkg::PM_STOP2) ||
                     (powerMode == crcgen_pkg::PM_STOP1);

  // wait is not decoded at all, so it behaves exactly as run
  assign accessOk = !frozen && !lostPower;

  assign writeHigh = accessOk && busReq.write && (busReq.addr == `CRCGEN_ADDR_HIGH);
  assign writeLow = accessOk && busReq.write && (busReq.addr == `CRCGEN_ADDR_LOW);
  assign readHigh = accessOk && busReq.read && (busReq.addr == `CRCGEN_ADDR_HIGH);
  assign readLow = accessOk && busReq.read && (busReq.addr == `CRCGEN_ADDR_LOW);

  // ------------------------------------------------------------------
  // seed sequencing
  // ------------------------------------------------------------------

  // a high write arms the low seed; a low write while idle is data
  always_comb begin
    seed_next = seed_reg;
    seedLowTaken = 1'b0;
    dataTaken = 1'b0;
    case (seed_reg)
      crcgen_pkg::SEED_IDLE: begin
        if (writeHigh) begin
          seed_next = crcgen_pkg::SEED_WAIT_LOW;
        end else if (writeLow) begin
          dataTaken = 1'b1;
        end
      end
      crcgen_pkg::SEED_WAIT_LOW: begin
        if (writeHigh) begin
          // a repeated high write restarts the seed
          seed_next = crcgen_pkg::SEED_WAIT_LOW;
        end else if (writeLow) begin
          seed_next = crcgen_pkg::SEED_IDLE;
          seedLowTaken = 1'b1;
        end
      end
      default: begin
        // unreachable code: fall back to the reset state
        seed_next = crcgen_pkg::SEED_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst || lostPower) begin
      seed_reg <= crcgen_pkg::SEED_IDLE;
    end else begin
      seed_reg <= seed_next;
    end
  end

  // ------------------------------------------------------------------
  // per-bit work: transpose taps and the eight feedback stages
  // ------------------------------------------------------------------

  assign stage[0] = shift_reg;

  // whole byte folded in one clock, so the shift register holds it next cycle
  for (genvar gi = 0; gi < 8; gi++) begin : g_bit
    assign dataRev[gi] = busReq.wdata[7 - gi];
    assign viewRev[gi] = shift_reg[15 - gi];
    assign viewRev[15 - gi] = shift_reg[gi];
    // msb of the data byte enters first
    assign feedBit[gi] = stage[gi][15] ^ dataByte[7 - gi];
    assign stage[gi + 1] = {stage[gi][14:0], 1'b0} ^ (feedBit[gi] ? POLY : 16'h0000);
  end

  // seed bytes are loaded raw; only data bytes are transposed
  assign dataByte = transposeEn ? dataRev : busReq.wdata;
  assign foldValue = stage[8];

  // ------------------------------------------------------------------
  // shift register
  // ------------------------------------------------------------------

  always_comb begin
    shift_next = shift_reg;
    if (writeHigh) begin
      shift_next = {busReq.wdata, shift_reg[7:0]};
    end else if (seedLowTaken) begin
      shift_next = {shift_reg[15:8], busReq.wdata};
    end else if (dataTaken) begin
      shift_next = foldValue;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || lostPower) begin
      shift_reg <= `CRCGEN_RESET_VALUE;
    end else begin
      shift_reg <= shift_next;
    end
  end

  // ------------------------------------------------------------------
  // read side
  // ------------------------------------------------------------------

  // transposed view is the full 16-bit bit reversal of the register
  assign viewValue = transposeEn ? viewRev : shift_reg;

  // a read and a write in one cycle return the value before the write
  always_comb begin
    readData_next = readData_reg;
    result_next = viewValue;
    if (readHigh) begin
      readData_next = viewValue[15:8];
    end else if (readLow) begin
      readData_next = viewValue[7:0];
    end
  end

  // outputs straight from flops; result lags the register by one cycle
  always_ff @(posedge clock) begin
    if (sys_rst || lostPower) begin
      readData_reg <= 8'h00;
      result_reg <= `CRCGEN_RESET_VALUE;
    end else begin
      readData_reg <= readData_next;
      result_reg <= result_next;
    end
  end

endmodule
`default_nettype wire

/* verification/crcgen_props.sv */
`timescale 1ns/1ps
`default_nettype none
module crcgen_props (
  // watched core ports
  input wire logic clock,
  input wire logic sys_rst,
  input wire crcgen_pkg::crcgen_pmode_t powerMode,
  input wire logic transposeEn,
  input wire crcgen_pkg::crcgen_bus_t busReq,
  input wire logic [7:0] readData_reg,
  input wire logic [15:0] result_reg
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_rd;
    busReq.read && powerMode < crcgen_pkg::PM_STOP3 |=> readData_reg ==
      ($past(busReq.addr) ? result_reg[7:0] : result_reg[15:8]);
  endproperty
  a_rd: assert property (p_rd) else $error("read byte differs from result");
  property p_st3; (powerMode == crcgen_pkg::PM_STOP3) [*2] |=> $stable(result_reg); endproperty
  a_st3: assert property (p_st3) else $error("result moved in standby");
  property p_st12; powerMode > crcgen_pkg::PM_STOP3 |=> result_reg == 16'h0000; endproperty
  a_st12: assert property (p_st12) else $error("deep stop kept state");
  sequence s_seedPair;
    (busReq.write && !busReq.addr && powerMode < crcgen_pkg::PM_STOP3) ##1
    (busReq.write && busReq.addr && powerMode < crcgen_pkg::PM_STOP3);
  endsequence
  property p_seed;
    s_seedPair ##1 (!transposeEn && powerMode < crcgen_pkg::PM_STOP3) |=>
      result_reg == {$past(busReq.wdata, 3), $past(busReq.wdata, 2)};
  endproperty
  a_seed: assert property (p_seed) else $error("seed bytes not loaded");
  sequence s_quiet;
    (!busReq.write && powerMode <= crcgen_pkg::PM_STOP3) ##1
    ($stable(transposeEn) && powerMode <= crcgen_pkg::PM_STOP3);
  endsequence
  property p_keep; s_quiet |=> $stable(result_reg); endproperty
  a_keep: assert property (p_keep) else $error("result moved without a write");
  property p_rdHold;
    !busReq.read && powerMode <= crcgen_pkg::PM_STOP3 |=> $stable(readData_reg);
  endproperty
  a_rdHold: assert property (p_rdHold) else $error("read byte moved without a read");
endmodule
bind crcgen_core crcgen_props u_props (.*);
`default_nettype wire

/* verification/crcgen_cpu.sv */
`timescale 1ns/1ps
`default_nettype none
module crcgen_cpu (
  // bus side of the processor
  input wire logic clock,
  output var crcgen_pkg::crcgen_bus_t busReq
);
  initial busReq = '0;
  // each call launches one access on the falling edge; back to back allowed
  task automatic wr(logic a, logic [7:0] d);
    @(negedge clock);
    busReq = '{1'b1, 1'b0, a, d};
  endtask
  task automatic rd(logic a);
    @(negedge clock);
    busReq = '{1'b0, 1'b1, a, ~busReq.wdata};
  endtask
  // idle data inverted so a stale byte never looks valid
  task automatic idle;
    @(negedge clock);
    busReq = '{1'b0, 1'b0, busReq.addr, ~busReq.wdata};
  endtask
endmodule
`default_nettype wire

/* verification/crcgen_core_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module crcgen_core_tb_top;
  logic clock = 1'b0, sys_rst = 1'b1, transposeEn = 1'b0;
  crcgen_pkg::crcgen_pmode_t powerMode = crcgen_pkg::PM_RUN;
  crcgen_pkg::crcgen_bus_t busReq;
  logic [7:0] readData_reg;
  logic [15:0] result_reg;
  int n_mismatch = 0, cmp_count = 0;
  always #2 clock = ~clock;
  crcgen_cpu cpu (.*);
  crcgen_core DUT (.*);
  task automatic chk(logic [15:0] got, exp);
    cmp_count++;
    n_mismatch += int'(got !== exp);
    if (got !== exp) $display("Error %0t: got %h want %h", $time, got, exp);
  endtask
  // mode applies to the data byte only; the read is made back in run
  task automatic t_crc(crcgen_pkg::crcgen_pmode_t m, logic tr, logic [7:0] d, logic [15:0] e);
    transposeEn = tr;
    cpu.wr(1'b0, 8'hff);
    cpu.wr(1'b1, 8'hff);
    cpu.wr(1'b1, d);
    powerMode = m;
    cpu.idle();
    cpu.idle();
    powerMode = crcgen_pkg::PM_RUN;
    cpu.rd(1'b0);
    cpu.idle();
    chk(result_reg, e);
    chk({8'h00, readData_reg}, {8'h00, e[15:8]});
    $display("crc case done");
  endtask
  // half seed left pending so a kept sequencing state shows
  task automatic t_stop(crcgen_pkg::crcgen_pmode_t m);
    cpu.wr(1'b0, 8'h12);
    cpu.idle();
    powerMode = m;
    @(negedge clock);
    powerMode = crcgen_pkg::PM_RUN;
    cpu.wr(1'b1, 8'h31);
    cpu.idle();
    @(negedge clock);
    chk(result_reg, 16'h2672);
    $display("deep stop done");
  endtask
  // mid-run reset with a half seed pending: the low write must be data
  task automatic t_rst;
    cpu.wr(1'b0, 8'h12);
    cpu.idle();
    sys_rst = 1'b1;
    @(negedge clock);
    sys_rst = 1'b0;
    cpu.wr(1'b1, 8'h31);
    cpu.idle();
    @(negedge clock);
    chk(result_reg, 16'h2672);
    $display("mid-run reset done");
  endtask
  task automatic final_report;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    t_crc(crcgen_pkg::PM_RUN, 1'b0, 8'h31, 16'hc782);
    t_crc(crcgen_pkg::PM_WAIT, 1'b1, 8'h8c, 16'h41e3);
    t_crc(crcgen_pkg::PM_STOP3, 1'b0, 8'h31, 16'hffff);
    t_stop(crcgen_pkg::PM_STOP1);
    t_stop(crcgen_pkg::PM_STOP2);
    t_rst();
    final_report();
  end
  // the whole run needs well under a hundred cycles
  initial begin
    #2000 n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
